//--- bmtt_pkg.sv
// bmtt_pkg: constants for the burst map table transfer unit.
// assumes one 16-bit programmed I/O bus, bit 0 = msb as printed.
package bmtt_pkg;
    localparam logic [5:0] BMTT_DEV_CODE = 6'h05;
    // instruction codes on the io bus
    localparam logic [2:0] BMTT_OP_NONE = 3'h0;
    localparam logic [2:0] BMTT_OP_RDC = 3'h1;
    localparam logic [2:0] BMTT_OP_WRA = 3'h2;
    localparam logic [2:0] BMTT_OP_WRB = 3'h3;
    localparam logic [2:0] BMTT_OP_WRC = 3'h4;
    // flag commands
    localparam logic [1:0] BMTT_F_NONE = 2'h0;
    localparam logic [1:0] BMTT_F_START = 2'h1;
    localparam logic [1:0] BMTT_F_CLEAR = 2'h2;
    localparam logic [1:0] BMTT_F_PULSE = 2'h3;
    // status bit positions, printed numbering (msb = 0)
    localparam int BMTT_ST_FLT = 0;
    localparam int BMTT_ST_DIR = 1;
    localparam int BMTT_ST_VF = 3;
    localparam int BMTT_ST_AF = 7;
    localparam int BMTT_ST_DF = 8;
    localparam int BMTT_ST_PRES = 15;
    localparam logic [15:0] BMTT_STATUS_RST = 16'h0001;
    localparam int BMTT_ENTRIES = 1024;
    localparam int BMTT_MAX_COUNT = 128;
endpackage

//--- bmtt_entry_table.sv
// bmtt_entry_table: the 1024-entry burst map table memory.
// assumes one read or write per cycle; read data lags address by one clock.
`timescale 1ns/1ps
module bmtt_entry_table import bmtt_pkg::*; #(
    parameter int DEPTH = BMTT_ENTRIES,
    parameter int AW = 10
) (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata
);
    logic [15:0] mem [DEPTH];

    // entry: bit0 validity (1 denies), bits 1-5 zero, 6-15 physical page
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[addr] <= {wdata[15], 5'h00, wdata[9:0]};
        end
        rdata <= mem[addr];
    end
endmodule

//--- bmtt_unit.sv
// bmtt_unit: io-bus side of the burst multiplexor translator; status,
// transfer setup and the map table load/dump engine.
// assumes io bus strobes are one-cycle pulses on core_clk; memory is a
// simple request/acknowledge port; fault events are one-cycle pulses.
// Operation
// - answer only device code five, no mask bit
// - io reset clears status except bit fifteen
// - no busy or done flag exists
// - start begins transfer, pulse does nothing
// - clear zeroes status except bits one, fifteen
// - status read first, flag command afterwards
// - bit zero is or of faults
// - faults at bits three, seven, eight
// - bit fifteen shows facility present
// - bit one direction, one means dump
// - port a sets low ten address bits
// - port b bit0 zero: direction, high address
// - port b bit0 one: initial entry index
// - port c bit0 zero: count minus one
// - one to 128 entries per transfer
// - table of 1024 entries, validity flag format
// - validity fault only sets status bit
`timescale 1ns/1ps
module bmtt_unit import bmtt_pkg::*; #(
    parameter int CW = 7
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic io_strobe,
    input wire logic [2:0] io_op,
    input wire logic [5:0] io_dev,
    input wire logic [1:0] io_flag,
    input wire logic [15:0] io_wdata,
    input wire logic io_bus_reset_instruction,
    input wire logic validity_fault_evt,
    input wire logic address_parity_fault_evt,
    input wire logic data_parity_fault_evt,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic [15:0] io_rdata,
    output logic io_rvalid,
    output logic mem_req,
    output logic mem_we,
    output logic [19:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic xfer_active
);
    typedef enum logic [1:0] {
        BMTT_IDLE = 2'b00,
        BMTT_FETCH = 2'b01,
        BMTT_MEMOP = 2'b11,
        BMTT_STORE = 2'b10
    } bmtt_state_t;

    typedef struct packed {
        bmtt_state_t st;
        logic act;
        logic dir;
        logic vf;
        logic af;
        logic df;
        logic [9:0] addr_hi;
        logic [9:0] addr_lo;
        logic [9:0] entry;
        logic [CW-1:0] count;
        logic [CW-1:0] left;
        logic [19:0] cur_addr;
        logic [15:0] rdata;
        logic rvalid;
        logic req;
        logic we;
        logic [15:0] wdata;
    } bmtt_regs_t;

    bmtt_regs_t q, d;
    logic [15:0] tbl_rdata;
    logic tbl_we;
    logic [9:0] tbl_addr;
    logic [15:0] status_w;
    logic sel;

    // status in printed order: index k maps to bit 15-k
    always_comb begin
        status_w = 16'h0000;
        status_w[15-BMTT_ST_FLT] = q.vf | q.af | q.df;
        status_w[15-BMTT_ST_DIR] = q.dir;
        status_w[15-BMTT_ST_VF] = q.vf;
        status_w[15-BMTT_ST_AF] = q.af;
        status_w[15-BMTT_ST_DF] = q.df;
        status_w[15-BMTT_ST_PRES] = 1'b1;
    end

    assign sel = io_strobe && (io_dev == BMTT_DEV_CODE);
    assign tbl_we = (q.st == BMTT_STORE) && !q.dir;
    // read address runs one cycle ahead (d.entry) so dump data is ready in fetch
    assign tbl_addr = tbl_we ? q.entry : d.entry;

    always_comb begin
        d = q;
        d.rvalid = 1'b0;
        // faults are sticky; events beat any clear in the same cycle
        if (sel && io_flag == BMTT_F_CLEAR) begin
            d.vf = 1'b0;
            d.af = 1'b0;
            d.df = 1'b0;
        end
        if (sel) begin
            unique case (io_op)
                BMTT_OP_RDC: begin
                    // status captured before the flag action takes effect
                    d.rdata = status_w;
                    d.rvalid = 1'b1;
                end
                BMTT_OP_WRA: d.addr_lo = io_wdata[9:0];
                BMTT_OP_WRB: begin
                    if (!io_wdata[15]) begin
                        d.dir = io_wdata[14];
                        d.addr_hi = io_wdata[9:0];
                    end else begin
                        d.entry = io_wdata[9:0];
                    end
                end
                BMTT_OP_WRC: begin
                    if (!io_wdata[15]) begin
                        d.count = io_wdata[CW-1:0];
                    end else begin
                        // diagnostic status load
                        d.dir = io_wdata[15-BMTT_ST_DIR];
                        d.vf = io_wdata[15-BMTT_ST_VF];
                        d.af = io_wdata[15-BMTT_ST_AF];
                        d.df = io_wdata[15-BMTT_ST_DF];
                    end
                end
                default: ;
            endcase
        end
        // io reset sits before the events so a fault in the same cycle survives
        if (io_bus_reset_instruction) begin
            d.dir = 1'b0;
            d.vf = 1'b0;
            d.af = 1'b0;
            d.df = 1'b0;
        end
        if (validity_fault_evt) d.vf = 1'b1;
        if (address_parity_fault_evt) d.af = 1'b1;
        if (data_parity_fault_evt) d.df = 1'b1;
        // clear leaves dir alone, a direction write with clear still sets it; pulse ignored
        unique case (q.st)
            BMTT_IDLE: begin
                if (sel && io_flag == BMTT_F_START) begin
                    d.cur_addr = {d.addr_hi, d.addr_lo};
                    d.left = d.count;
                    d.st = BMTT_FETCH;
                end
            end
            BMTT_FETCH: begin
                // table read data valid now for a dump
                d.req = 1'b1;
                d.we = q.dir;
                d.wdata = tbl_rdata;
                d.st = BMTT_MEMOP;
            end
            BMTT_MEMOP: begin
                if (mem_ack) begin
                    d.req = 1'b0;
                    d.we = 1'b0;
                    d.rdata = q.rdata;
                    d.wdata = q.dir ? q.wdata : mem_rdata;
                    d.st = BMTT_STORE;
                end
            end
            BMTT_STORE: begin
                d.cur_addr = q.cur_addr + 20'h00001;
                d.entry = q.entry + 10'h001;
                d.left = q.left - 1'b1;
                d.st = (q.left == '0) ? BMTT_IDLE : BMTT_FETCH;
            end
            default: d.st = BMTT_IDLE;
        endcase
        // registered copy of the state test, so the pin comes from a flop
        d.act = (d.st != BMTT_IDLE);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    bmtt_entry_table #(.DEPTH(BMTT_ENTRIES), .AW(10)) u_table (
        .core_clk(core_clk),
        .we(tbl_we),
        .addr(tbl_addr),
        .wdata(q.wdata),
        .rdata(tbl_rdata)
    );

    // no busy/done flag is exposed in status; xfer_active is a pin only
    assign io_rdata = q.rdata;
    assign io_rvalid = q.rvalid;
    assign mem_req = q.req;
    assign mem_we = q.we;
    assign mem_addr = q.cur_addr;
    assign mem_wdata = q.wdata;
    assign xfer_active = q.act;
endmodule

//--- bmtt_unit_props.sv
// bmtt_unit_props: io bus and memory port checks.
// assumes bound into bmtt_unit, status in printed bit order.
`timescale 1ns/1ps
module bmtt_unit_props import bmtt_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic io_strobe,
    input wire logic [2:0] io_op,
    input wire logic [5:0] io_dev,
    input wire logic [1:0] io_flag,
    input wire logic mem_ack,
    input wire logic [15:0] io_rdata,
    input wire logic io_rvalid,
    input wire logic mem_req,
    input wire logic [19:0] mem_addr,
    input wire logic xfer_active
);
    wire hit = io_strobe && io_dev == BMTT_DEV_CODE;
    logic [19:0] last_q;
    logic mid_q;
    // mid_q: past the first entry, so a step is expected
    always_ff @(posedge core_clk) begin
        if (mem_req && mem_ack) last_q <= mem_addr;
        mid_q <= !rst && xfer_active && (mid_q || (mem_req && mem_ack));
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_read_answer: assert property (hit && io_op == BMTT_OP_RDC |=> io_rvalid)
        else $error("no status answer");
    chk_foreign_dev: assert property (io_strobe && !hit |=> !io_rvalid)
        else $error("foreign code answered");
    chk_present_bit: assert property (io_rvalid |-> io_rdata[0])
        else $error("present bit low");
    chk_fault_sum: assert property (io_rvalid |-> io_rdata[15] == |{io_rdata[12], io_rdata[8:7]})
        else $error("fault summary wrong");
    chk_start_runs: assert property (hit && io_flag == BMTT_F_START
        && !xfer_active |=> xfer_active) else $error("start ignored");
    chk_pulse_idle: assert property (hit && io_flag == BMTT_F_PULSE
        && !xfer_active |=> !xfer_active) else $error("pulse started");
    chk_req_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("request dropped");
    chk_addr_step: assert property ($rose(mem_req) && mid_q |-> mem_addr == last_q + 20'h1)
        else $error("address not stepped");
endmodule
bind bmtt_unit bmtt_unit_props u_props (
    .core_clk(core_clk),
    .rst(rst),
    .io_strobe(io_strobe),
    .io_op(io_op),
    .io_dev(io_dev),
    .io_flag(io_flag),
    .mem_ack(mem_ack),
    .io_rdata(io_rdata),
    .io_rvalid(io_rvalid),
    .mem_req(mem_req),
    .mem_addr(mem_addr),
    .xfer_active(xfer_active)
);

//--- bmtt_mem_model.sv
// bmtt_mem_model: main memory behind the transfer port.
// assumes each request is held until acknowledged.
`timescale 1ns/1ps
module bmtt_mem_model (
    input wire logic core_clk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic mem_ack = 1'h0,
    output logic [15:0] mem_rdata = 16'h0000
);
    logic [15:0] mem [logic [19:0]];
    int lat = 0, w = 0;
    always @(posedge core_clk) begin
        mem_ack <= 1'h0;
        mem_rdata <= ~mem_rdata; // idle data never looks valid
        w <= mem_req && !mem_ack ? w + 1 : 0;
        if (mem_req && !mem_ack && w >= lat) begin
            w <= 0;
            mem_ack <= 1'h1;
            if (mem_we) mem[mem_addr] = mem_wdata;
            else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : {6'h00, mem_addr[9:0]};
        end
    end
endmodule

//--- testbench.sv
// testbench: drives bmtt_unit over the io bus, judges status and transfers.
// assumes bmtt_mem_model as main memory.
`timescale 1ns/1ps
module testbench import bmtt_pkg::*;;
    logic core_clk = 1'h0, rst = 1'h1, io_strobe = 1'h0, io_bus_reset_instruction = 1'h0;
    logic validity_fault_evt = 1'h0, address_parity_fault_evt = 1'h0;
    logic data_parity_fault_evt = 1'h0, mem_ack, mem_req, mem_we, io_rvalid, xfer_active;
    logic [2:0] io_op = 3'h0;
    logic [5:0] io_dev = 6'h05;
    logic [1:0] io_flag = 2'h0;
    logic [15:0] io_wdata = 16'h0000, mem_rdata, io_rdata, mem_wdata;
    logic [19:0] mem_addr;
    int n_fail = 0, comparisons = 0;
    bmtt_unit u_bmtt_unit (
        .core_clk(core_clk),
        .rst(rst),
        .io_strobe(io_strobe),
        .io_op(io_op),
        .io_dev(io_dev),
        .io_flag(io_flag),
        .io_wdata(io_wdata),
        .io_bus_reset_instruction(io_bus_reset_instruction),
        .validity_fault_evt(validity_fault_evt),
        .address_parity_fault_evt(address_parity_fault_evt),
        .data_parity_fault_evt(data_parity_fault_evt),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata),
        .io_rdata(io_rdata),
        .io_rvalid(io_rvalid),
        .mem_req(mem_req),
        .mem_we(mem_we),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .xfer_active(xfer_active)
    );
    bmtt_mem_model u_bmtt_mem_model (
        .core_clk(core_clk),
        .mem_req(mem_req),
        .mem_we(mem_we),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata)
    );
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        #400000 n_fail++;
        end_of_test();
    end
    task automatic end_of_test();
        if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic io(input logic [2:0] op, input logic [1:0] f, input logic [15:0] d,
        input logic [5:0] dv = 6'h05);
        @(negedge core_clk);
        {io_strobe, io_op, io_flag, io_wdata, io_dev} = {1'h1, op, f, d, dv};
        @(negedge core_clk);
        io_strobe = 1'h0;
    endtask
    task automatic rd(input logic [1:0] f, input logic [15:0] e);
        io(BMTT_OP_RDC, f, 16'h0000);
        chk("status", e, io_rvalid === 1'h1 ? io_rdata : 16'hXXXX);
    endtask
    task automatic t_status();
        rd(BMTT_F_NONE, 16'h0001);
        io(BMTT_OP_WRB, BMTT_F_NONE, 16'h4000, 6'h06);
        rd(BMTT_F_NONE, 16'h0001);
        io(BMTT_OP_WRB, BMTT_F_NONE, 16'h4000);
        {validity_fault_evt, address_parity_fault_evt, data_parity_fault_evt} = 3'h7;
        @(negedge core_clk);
        {validity_fault_evt, address_parity_fault_evt, data_parity_fault_evt} = 3'h0;
        rd(BMTT_F_PULSE, 16'hD181);
        rd(BMTT_F_CLEAR, 16'hD181);
        rd(BMTT_F_NONE, 16'h4001);
        io_bus_reset_instruction = 1'h1;
        @(negedge core_clk);
        io_bus_reset_instruction = 1'h0;
        rd(BMTT_F_NONE, 16'h0001);
        io(BMTT_OP_WRC, BMTT_F_NONE, 16'h9080);
        rd(BMTT_F_CLEAR, 16'h9081);
        rd(BMTT_F_NONE, 16'h0001);
    endtask
    // entry index, count, then the start: the order software must keep
    task automatic xfer(input logic [9:0] lo, input int n, input logic transfer_direction);
        int acks;
        acks = 0;
        io(BMTT_OP_WRA, BMTT_F_NONE, {6'h00, lo});
        io(BMTT_OP_WRB, BMTT_F_NONE, 16'h8010);
        io(BMTT_OP_WRC, BMTT_F_NONE, 16'(n - 1));
        io(BMTT_OP_WRB, BMTT_F_START, {1'h0, transfer_direction, 14'h0001});
        for (int i = 0; i < 3000 && (i < 2 || xfer_active); i++) begin
            @(negedge core_clk);
            acks += int'(mem_ack === 1'h1);
        end
        chk("entries", 16'(n), 16'(acks));
    endtask
    task automatic t_xfer();
        xfer(10'h003, 4, 1'h0);
        u_bmtt_mem_model.lat = 3;
        xfer(10'h020, 4, 1'h1);
        for (int i = 0; i < 4; i++) begin
            chk("dump", 16'h0003 + 16'(i), u_bmtt_mem_model.mem[20'h00420 + 20'(i)]);
        end
        rd(BMTT_F_NONE, 16'h4001);
        xfer(10'h000, 128, 1'h0);
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'h0;
        t_status();
        t_xfer();
        end_of_test();
    end
endmodule
